/* scp_consts.svh */
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// register addresses, 10-bit serial address space
`define SCP_ADDR_W 10
`define SCP_ADDR_CFG 10'h000
`define SCP_ADDR_RBSEL 10'h004
`define SCP_ADDR_PDSYNC 10'h230
`define SCP_ADDR_RSVD 10'h231
`define SCP_ADDR_UPDATE 10'h232

// banked storage covers 0x000..0x232
`define SCP_BANK_DEPTH 563

// field positions
`define SCP_CFG_SDO_BIT 7
`define SCP_CFG_LSB_BIT 6
`define SCP_CFG_SRST_BIT 5
`define SCP_CFG_LONG_BIT 4
`define SCP_RBSEL_ACTIVE_BIT 0
`define SCP_UPDATE_BIT 0

// reset values
`define SCP_CFG_DEFAULT 8'h18
`define SCP_CFG_KEEP_MASK 8'h24
`define SCP_RBSEL_DEFAULT 8'h00
`define SCP_BANK_DEFAULT 8'h00
`define SCP_RSVD_VALUE 8'h00

// instruction word layout
`define SCP_INSTR_LAST 4'hf
`define SCP_BYTE_LAST 4'h7
`define SCP_INSTR_RW_BIT 15
`define SCP_INSTR_W_HI 14
`define SCP_INSTR_W_LO 13
`define SCP_STREAM_CODE 2'h3

`endif

/* scp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic sclk_o,
  output logic csb_n_o,
  output logic sdio_o,
  input wire logic sdio_i,
  input wire logic sdo_i
);
  logic lsb = 1'b0;
  logic pick_sdo = 1'b0;
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
  end
  // released data pin toggles so a stale value never reads as good
  task automatic shift(input logic drive, input logic b, output logic got);
    sdio_o <= drive ? b : ~sdio_o;
    sclk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    got = pick_sdo ? sdo_i : sdio_i;
    sclk_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : shift
  task automatic xfer(input logic rd, input logic [9:0] a, input int n, input logic [23:0] wd,
                      output logic [23:0] q);
    logic [15:0] ins;
    logic g;
    int k;
    ins = {rd, 2'(n - 1), 3'h0, a};
    q = 24'h0;
    csb_n_o <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 16; i++) shift(1'b1, ins[lsb ? i : 15 - i], g);
    for (int i = 0; i < 8 * n; i++) begin
      k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
      shift(!rd, wd[k], g);
      q[k] = g;
    end
    sclk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    csb_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : xfer
endmodule : scp_host_model
`default_nettype wire

/* scp_pkg.sv */
package scp_pkg;
  `include "scp_consts.svh"

  typedef enum logic [1:0] {
    SCP_IDLE,
    SCP_INSTR,
    SCP_WDATA,
    SCP_RDATA
  } scp_state_t;

  typedef struct packed {
    logic separate_readout_pin_enable;
    logic lsb_first;
    logic soft_reset;
    logic long_instr;
    logic [3:0] mirror;
  } scp_cfg_t;

  typedef struct packed {
    logic sdio;
    logic sdio_oe_n;
    logic serial_data_out_pin;
    logic sdo_oe_n;
  } scp_pins_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } scp_edges_t;

  typedef struct packed {
    logic we;
    logic [`SCP_ADDR_W-1:0] addr;
    logic [7:0] data;
  } scp_wr_t;
endpackage : scp_pkg

/* scp_port_chk_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_port_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // serial pins
  input wire logic csb_n_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_n_o,
  input wire logic serial_data_out_pin_o,
  input wire logic serial_data_out_pin_oe_n_o,
  // live controls
  input wire logic [7:0] power_down_sync_o,
  input wire logic separate_readout_pin_enable_o,
  input wire logic lsb_first_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  pin_shared_a: assert property (!separate_readout_pin_enable_o |-> serial_data_out_pin_oe_n_o)
    else $error("output pin driven in shared mode");
  pin_split_a: assert property (separate_readout_pin_enable_o |-> sdio_oe_n_o)
    else $error("data pin driven in split mode");
  oe_release_a: assert property (csb_n_i |=> sdio_oe_n_o && serial_data_out_pin_oe_n_o)
    else $error("pin still driven after deselect");
  // the instruction alone takes over 30 cycles, so no drive so early
  oe_start_a: assert property ($fell(csb_n_i) |-> (sdio_oe_n_o && serial_data_out_pin_oe_n_o) [*8])
    else $error("pin driven before instruction ends");
  same_bit_a: assert property (!sdio_oe_n_o || !serial_data_out_pin_oe_n_o |-> sdio_o == serial_data_out_pin_o)
    else $error("pin values differ");
  reset_vals_a: assert property ($rose(nrst_i) |-> power_down_sync_o == 8'h00 && !separate_readout_pin_enable_o && !lsb_first_o)
    else $error("wrong values after reset");
  live_frame_a: assert property ($changed(power_down_sync_o) |-> !$past(csb_n_i))
    else $error("live register moved outside a frame");
  cfg_frame_a: assert property ($changed(lsb_first_o) || $changed(separate_readout_pin_enable_o) |-> !$past(csb_n_i))
    else $error("config moved outside a frame");
  cover property (!serial_data_out_pin_oe_n_o);
  cover property (!sdio_oe_n_o && lsb_first_o);
  cover property ($changed(power_down_sync_o) && power_down_sync_o != 8'h00);
endmodule : scp_port_chk
bind scp_serial_port scp_port_chk chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .csb_n_i(csb_n_i),
  .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .serial_data_out_pin_o(serial_data_out_pin_o),
  .serial_data_out_pin_oe_n_o(serial_data_out_pin_oe_n_o), .power_down_sync_o(power_down_sync_o),
  .separate_readout_pin_enable_o(separate_readout_pin_enable_o), .lsb_first_o(lsb_first_o));
`default_nettype wire

/* scp_reg_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
module scp_reg_bank (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // control
  input wire scp_pkg::scp_wr_t wr_i,
  input wire logic update_i,
  input wire logic soft_reset_i,
  // readback
  input wire logic [`SCP_ADDR_W-1:0] rd_addr_i,
  input wire logic rd_active_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] live_pdsync_o
);
  typedef struct packed {
    logic [`SCP_BANK_DEPTH-1:0][7:0] staged;
    logic [`SCP_BANK_DEPTH-1:0][7:0] live;
  } scp_bank_st_t;

  scp_bank_st_t st_ff;
  scp_bank_st_t nxt_st;

  function automatic logic in_bank(input logic [`SCP_ADDR_W-1:0] a);
    in_bank = (a < `SCP_ADDR_W'(`SCP_BANK_DEPTH));
  endfunction : in_bank

  always_comb begin
    nxt_st = st_ff;
    if (soft_reset_i) begin
      // held at defaults for as long as the bit stays set
      nxt_st.staged = {`SCP_BANK_DEPTH{`SCP_BANK_DEFAULT}};
      nxt_st.live = {`SCP_BANK_DEPTH{`SCP_BANK_DEFAULT}};
    end else begin
      if (wr_i.we && in_bank(wr_i.addr)) begin
        nxt_st.staged[wr_i.addr] = wr_i.data;
      end
      // copy uses the staged set as it was before this cycle's write
      if (update_i) begin
        nxt_st.live = st_ff.staged;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= {2{{`SCP_BANK_DEPTH{`SCP_BANK_DEFAULT}}}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    rd_data_o = 8'h00;
    if (in_bank(rd_addr_i)) begin
      rd_data_o = rd_active_i ? st_ff.live[rd_addr_i] : st_ff.staged[rd_addr_i];
    end
  end

  assign live_pdsync_o = st_ff.live[`SCP_ADDR_PDSYNC];
endmodule : scp_reg_bank
`default_nettype wire

/* scp_sclk_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_sclk_edge (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic csb_n_i,
  // events
  output var scp_pkg::scp_edges_t edges_o
);
  typedef struct packed {
    logic sclk_q;
    logic csb_q;
  } scp_edge_st_t;

  scp_edge_st_t st_ff;
  scp_edge_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_q = sclk_i;
    nxt_st.csb_q = csb_n_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '{sclk_q: 1'b0, csb_q: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // clock edges and start only count while the port is selected; stop fires on deselect
  assign edges_o.rise = ~csb_n_i & sclk_i & ~st_ff.sclk_q;
  assign edges_o.fall = ~csb_n_i & ~sclk_i & st_ff.sclk_q;
  assign edges_o.start = ~csb_n_i & st_ff.csb_q;
  assign edges_o.stop = csb_n_i & ~st_ff.csb_q;
endmodule : scp_sclk_edge
`default_nettype wire

/* scp_serial_port.sv */
`timescale 1ns/100ps
`default_nettype none
`include "scp_consts.svh"
// Overview of operation
// - pin-arrangement 0: reads and writes on the data pin, output pin released.
// - pin-arrangement 1: writes on the data pin, read data only on output pin.
// - bit order 1: shift least significant bit first, address steps upward.
// - bit order 0: shift most significant bit first, address steps downward.
// - soft reset bit loads defaults everywhere else; it and its mirror bit stay as written.
// - instructions are always 16 bits; host keeps the length bit at one.
// - readback select 0 returns the staged buffer registers.
// - readback select 1 returns the live registers in effect.
module scp_serial_port (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // serial control pins
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_n_o,
  // live controls for the rest of the chip
  output logic [7:0] power_down_sync_o,
  output logic separate_readout_pin_enable_o,
  output logic lsb_first_o
);
  typedef struct packed {
    scp_pkg::scp_state_t state;
    logic [15:0] sh;
    logic [3:0] bitcnt;
    logic [`SCP_ADDR_W-1:0] addr;
    logic [1:0] bytes_left;
    logic stream;
    scp_pkg::scp_cfg_t cfg;
    logic [7:0] rbsel;
    logic [7:0] osh;
    scp_pkg::scp_pins_t pins;
    logic [7:0] pdsync;
  } scp_top_st_t;

  scp_top_st_t st_ff;
  scp_top_st_t nxt_st;
  scp_pkg::scp_edges_t edges;
  scp_pkg::scp_wr_t bank_wr;
  logic bank_update;
  logic [`SCP_ADDR_W-1:0] rd_addr;
  logic [7:0] bank_rdata;
  logic [7:0] live_pdsync;
  logic [15:0] shifted;
  logic [7:0] rd_byte;

  scp_sclk_edge u_edge (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .sclk_i(sclk_i),
    .csb_n_i(csb_n_i),
    .edges_o(edges)
  );

  scp_reg_bank u_bank (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .wr_i(bank_wr),
    .update_i(bank_update),
    .soft_reset_i(st_ff.cfg.soft_reset),
    .rd_addr_i(rd_addr),
    .rd_active_i(st_ff.rbsel[`SCP_RBSEL_ACTIVE_BIT]),
    .rd_data_o(bank_rdata),
    .live_pdsync_o(live_pdsync)
  );

  // incoming bit enters at the end that keeps the first bit as the far end
  function automatic logic [15:0] shift_in(input logic [15:0] v, input logic d, input logic lsb);
    shift_in = lsb ? {d, v[15:1]} : {v[14:0], d};
  endfunction : shift_in

  function automatic logic [`SCP_ADDR_W-1:0] step_addr(input logic [`SCP_ADDR_W-1:0] a, input logic lsb);
    step_addr = lsb ? `SCP_ADDR_W'(a + 1'b1) : `SCP_ADDR_W'(a - 1'b1);
  endfunction : step_addr

  assign shifted = shift_in(st_ff.sh, sdio_i, st_ff.cfg.lsb_first);
  assign rd_addr = (st_ff.state == scp_pkg::SCP_INSTR) ? shifted[`SCP_ADDR_W-1:0]
                                                      : step_addr(st_ff.addr, st_ff.cfg.lsb_first);

  // readback mux over direct and banked registers
  always_comb begin
    rd_byte = bank_rdata;
    if (rd_addr == `SCP_ADDR_CFG) begin
      rd_byte = st_ff.cfg;
    end else if (rd_addr == `SCP_ADDR_RBSEL) begin
      rd_byte = st_ff.rbsel;
    end else if (rd_addr == `SCP_ADDR_RSVD) begin
      rd_byte = `SCP_RSVD_VALUE;
    end else if (rd_addr == `SCP_ADDR_UPDATE) begin
      // strobe is gone by the time anyone can read it
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    logic [7:0] wbyte;
    logic done;
    wbyte = 8'h00;
    done = 1'b0;
    nxt_st = st_ff;
    bank_wr = '0;
    bank_update = 1'b0;
    case (st_ff.state)
      scp_pkg::SCP_IDLE: begin
        if (edges.start) begin
          nxt_st.state = scp_pkg::SCP_INSTR;
          nxt_st.bitcnt = 4'h0;
        end
      end
      scp_pkg::SCP_INSTR: begin
        if (edges.rise) begin
          nxt_st.sh = shifted;
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          // length bit is not consulted: only the long form is decoded
          if (st_ff.bitcnt == `SCP_INSTR_LAST) begin
            nxt_st.bitcnt = 4'h0;
            nxt_st.addr = shifted[`SCP_ADDR_W-1:0];
            nxt_st.bytes_left = shifted[`SCP_INSTR_W_HI:`SCP_INSTR_W_LO];
            nxt_st.stream = (shifted[`SCP_INSTR_W_HI:`SCP_INSTR_W_LO] == `SCP_STREAM_CODE);
            if (shifted[`SCP_INSTR_RW_BIT]) begin
              nxt_st.state = scp_pkg::SCP_RDATA;
              nxt_st.osh = rd_byte;
            end else begin
              nxt_st.state = scp_pkg::SCP_WDATA;
            end
          end
        end
      end
      scp_pkg::SCP_WDATA: begin
        if (edges.rise) begin
          nxt_st.sh = shifted;
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          if (st_ff.bitcnt == `SCP_BYTE_LAST) begin
            wbyte = st_ff.cfg.lsb_first ? shifted[15:8] : shifted[7:0];
            nxt_st.bitcnt = 4'h0;
            if (st_ff.addr == `SCP_ADDR_CFG) begin
              nxt_st.cfg = wbyte;
              if (wbyte[`SCP_CFG_SRST_BIT]) begin
                // soft reset keeps its own bit and mirror so the host must clear it
                nxt_st.cfg = (`SCP_CFG_DEFAULT & ~`SCP_CFG_KEEP_MASK) | (wbyte & `SCP_CFG_KEEP_MASK);
              end
            end else if (st_ff.addr == `SCP_ADDR_RBSEL) begin
              nxt_st.rbsel = wbyte;
            end else if (st_ff.addr == `SCP_ADDR_UPDATE) begin
              bank_update = wbyte[`SCP_UPDATE_BIT];
            end else if (st_ff.addr != `SCP_ADDR_RSVD) begin
              bank_wr.we = 1'b1;
              bank_wr.addr = st_ff.addr;
              bank_wr.data = wbyte;
            end
            nxt_st.addr = step_addr(st_ff.addr, st_ff.cfg.lsb_first);
            done = ~st_ff.stream && (st_ff.bytes_left == 2'h0);
            nxt_st.bytes_left = st_ff.bytes_left - 2'h1;
            if (done) begin
              nxt_st.state = scp_pkg::SCP_IDLE;
            end
          end
        end
      end
      scp_pkg::SCP_RDATA: begin
        if (edges.fall) begin
          nxt_st.pins.sdio = st_ff.cfg.lsb_first ? st_ff.osh[0] : st_ff.osh[7];
          nxt_st.pins.serial_data_out_pin = nxt_st.pins.sdio;
          nxt_st.osh = st_ff.cfg.lsb_first ? {1'b0, st_ff.osh[7:1]} : {st_ff.osh[6:0], 1'b0};
        end
        if (edges.rise) begin
          nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          if (st_ff.bitcnt == `SCP_BYTE_LAST) begin
            nxt_st.bitcnt = 4'h0;
            nxt_st.addr = rd_addr;
            nxt_st.osh = rd_byte;
            done = ~st_ff.stream && (st_ff.bytes_left == 2'h0);
            nxt_st.bytes_left = st_ff.bytes_left - 2'h1;
            if (done) begin
              nxt_st.state = scp_pkg::SCP_IDLE;
            end
          end
        end
      end
      default: begin
        nxt_st.state = scp_pkg::SCP_IDLE;
      end
    endcase

    // deselect ends any transfer, even mid-byte
    if (edges.stop) begin
      nxt_st.state = scp_pkg::SCP_IDLE;
    end

    // readback select also returns to default while soft reset is held
    if (st_ff.cfg.soft_reset) begin
      nxt_st.rbsel = `SCP_RBSEL_DEFAULT;
    end

    // only one pin drives read data, chosen by the arrangement bit
    nxt_st.pins.sdio_oe_n = 1'b1;
    nxt_st.pins.sdo_oe_n = 1'b1;
    if (nxt_st.state == scp_pkg::SCP_RDATA) begin
      if (nxt_st.cfg.separate_readout_pin_enable) begin
        nxt_st.pins.sdo_oe_n = 1'b0;
      end else begin
        nxt_st.pins.sdio_oe_n = 1'b0;
      end
    end
    nxt_st.pdsync = live_pdsync;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= '{state: scp_pkg::SCP_IDLE, sh: 16'h0000, bitcnt: 4'h0, addr: 10'h000, bytes_left: 2'h0,
                 stream: 1'b0, cfg: `SCP_CFG_DEFAULT, rbsel: `SCP_RBSEL_DEFAULT, osh: 8'h00,
                 pins: '{sdio: 1'b0, sdio_oe_n: 1'b1, serial_data_out_pin: 1'b0, sdo_oe_n: 1'b1},
                 pdsync: `SCP_BANK_DEFAULT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdio_o = st_ff.pins.sdio;
  assign sdio_oe_n_o = st_ff.pins.sdio_oe_n;
  assign serial_data_out_pin_o = st_ff.pins.serial_data_out_pin;
  assign serial_data_out_pin_oe_n_o = st_ff.pins.sdo_oe_n;
  assign power_down_sync_o = st_ff.pdsync;
  assign separate_readout_pin_enable_o = st_ff.cfg.separate_readout_pin_enable;
  assign lsb_first_o = st_ff.cfg.lsb_first;
endmodule : scp_serial_port
`default_nettype wire

/* scp_serial_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_serial_port_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, csb_n, h_sdio, sdio_w, sdo_w, d_sdio, d_oe_n, d_sdo, d_sdo_oe_n, act, lsb;
  logic [7:0] pds;
  logic [23:0] q;
  int bad_count = 0;
  int check_count = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  assign sdio_w = !d_oe_n ? d_sdio : h_sdio;
  assign sdo_w = !d_sdo_oe_n ? d_sdo : ~h_sdio;
  scp_host_model host (.clk_i(clk), .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(h_sdio), .sdio_i(sdio_w),
    .sdo_i(sdo_w));
  scp_serial_port uut (.core_clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .csb_n_i(csb_n), .sdio_i(sdio_w),
    .sdio_o(d_sdio), .sdio_oe_n_o(d_oe_n), .serial_data_out_pin_o(d_sdo),
    .serial_data_out_pin_oe_n_o(d_sdo_oe_n), .power_down_sync_o(pds), .separate_readout_pin_enable_o(act), .lsb_first_o(lsb));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [9:0] a, input int n, input logic [23:0] d);
    host.xfer(1'b0, a, n, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, input int n, input logic [23:0] e);
    host.xfer(1'b1, a, n, 24'h0, q);
    check(q, e);
  endtask : rd
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(24'({d_oe_n, d_sdo_oe_n, act, lsb, pds}), 24'hc00);
    rd(10'h000, 1, 24'h18);
    rd(10'h004, 1, 24'h00);
    $display("test reset done");
    wr(10'h230, 2, 24'h3ca5);
    rd(10'h230, 2, 24'h3ca5);
    check(24'(pds), 24'h00);
    wr(10'h004, 1, 24'h01);
    rd(10'h230, 1, 24'h00);
    wr(10'h232, 1, 24'h01);
    check(24'(pds), 24'ha5);
    rd(10'h230, 2, 24'h3ca5);
    wr(10'h231, 1, 24'hff);
    rd(10'h232, 2, 24'h0000);
    wr(10'h230, 1, 24'h5a);
    rd(10'h230, 1, 24'ha5);
    wr(10'h004, 1, 24'h00);
    rd(10'h230, 1, 24'h5a);
    $display("test banks done");
    // mirrored nibbles keep every config byte order-independent
    wr(10'h000, 1, 24'h5a);
    host.lsb = 1'b1;
    check(24'(lsb), 24'h1);
    wr(10'h010, 2, 24'h6699);
    rd(10'h010, 2, 24'h6699);
    rd(10'h011, 1, 24'h66);
    wr(10'h000, 1, 24'hdb);
    host.pick_sdo = 1'b1;
    check(24'(act), 24'h1);
    rd(10'h011, 1, 24'h66);
    wr(10'h000, 1, 24'h18);
    host.lsb = 1'b0;
    host.pick_sdo = 1'b0;
    rd(10'h010, 1, 24'h99);
    $display("test order and pins done");
    wr(10'h004, 1, 24'h01);
    wr(10'h000, 1, 24'h3c);
    rd(10'h000, 1, 24'h3c);
    check(24'(pds), 24'h00);
    wr(10'h000, 1, 24'h18);
    rd(10'h004, 1, 24'h00);
    rd(10'h230, 1, 24'h00);
    $display("test soft reset done");
    close_out();
  end
endmodule : scp_serial_port_bench
`default_nettype wire
